// >>> include/ped_pkg.sv
// Event codes and widths for the event-qualification block
`default_nettype none
package ped_pkg;
    localparam int SEL_W = 8;
    localparam int INC_W = 2;
    localparam int FP_EXC_W = 4;
    localparam int BP_W = 4;
    localparam logic [SEL_W-1:0] CODE_UNCACHED_READ = 8'h1E;
    localparam logic [SEL_W-1:0] CODE_INTERLOCK_STALL = 8'h1F;
    localparam logic [SEL_W-1:0] CODE_RESERVED_A = 8'h20;
    localparam logic [SEL_W-1:0] CODE_RESERVED_B = 8'h21;
    localparam logic [SEL_W-1:0] CODE_FLOAT_OP = 8'h22;
    localparam logic [SEL_W-1:0] CODE_BREAKPOINT_0 = 8'h23;
    localparam logic [INC_W-1:0] INC_NONE = 2'h0;
    localparam logic [INC_W-1:0] INC_ONE = 2'h1;
    localparam int BP0_BIT = 0;
endpackage
`default_nettype wire

// >>> rtl/ped_event_detect.sv
// Qualifies performance events 1EH to 23H and routes them to two counters
// What this block does
// - Count each noncacheable memory read bus cycle.
// - Reads to I/O space never count.
// - Backoff-restarted read cycle is not recounted.
// - Count every address-generation interlock stall.
// - Interlocks in both pipes give two counts.
// - Count float add, sub, mul, div, rem, sqrt.
// - Each internal transcendental step counts once.
// - Four excluded exception kinds suppress the count.
// - Other float exceptions still count.
// - Integer multiply and other float-unit work counts.
// - First pipe address 0 matches count regardless of enable.
// - Disabled: second pipe matches are not checked.
// - Disabled: first pipe matches still checked, counted.
// - Match count coincides with match pin.
`default_nettype none
module ped_event_detect
    import ped_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_bus_read_start,
    input wire logic i_bus_read_noncacheable,
    input wire logic i_bus_read_io,
    input wire logic i_bus_read_done,
    input wire logic i_bus_backoff_input_n,
    input wire logic i_address_interlock_stall_first,
    input wire logic i_address_interlock_stall_second,
    input wire logic i_float_op_valid,
    input wire logic [ped_pkg::FP_EXC_W-1:0] i_float_excluded_exc,
    input wire logic i_breakpoints_enabled,
    input wire logic i_bp0_hit_first,
    input wire logic i_bp0_hit_second,
    input wire logic [ped_pkg::BP_W-1:1] i_bp_hit_other,
    input wire logic [ped_pkg::SEL_W-1:0] i_event_select_0,
    input wire logic [ped_pkg::SEL_W-1:0] i_event_select_1,
    output logic [ped_pkg::BP_W-1:0] o_breakpoint_match_pins,
    output logic [ped_pkg::INC_W-1:0] o_increment_0,
    output logic [ped_pkg::INC_W-1:0] o_increment_1
);
    logic backoff_meta;
    logic backoff_sync;
    logic read_active;
    logic restart_pending;
    logic memory_read;
    logic uncached_hit;
    logic float_hit;
    logic bp0_first;
    logic bp0_second;
    logic [INC_W-1:0] uncached_inc;
    logic [INC_W-1:0] interlock_inc;
    logic [INC_W-1:0] float_inc;
    logic [INC_W-1:0] bp0_inc;
    logic [BP_W-1:0] next_pins;
    logic [INC_W-1:0] past_uncached;
    logic [INC_W-1:0] past_interlock;
    logic [INC_W-1:0] past_float;
    logic [INC_W-1:0] past_bp0;
    logic past_bp0_pin;

    // ----------------------------------------
    // Backoff pin synchroniser
    // ----------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            backoff_meta <= 1'b0;
            backoff_sync <= 1'b0;
        end
        else
        begin
            backoff_meta <= !i_bus_backoff_input_n;
            backoff_sync <= backoff_meta;
        end
    end

    // ----------------------------------------
    // Noncacheable memory read qualification
    // ----------------------------------------
    // Memory space only, noncacheable, instruction or data, incl. TLB walks
    assign memory_read = i_bus_read_start && i_bus_read_noncacheable && !i_bus_read_io;
    assign uncached_hit = memory_read && !restart_pending;
    assign uncached_inc = {1'b0, uncached_hit};

    // Tracks a counted read so its backoff restart is not counted again
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            read_active <= 1'b0;
            restart_pending <= 1'b0;
        end
        else
        begin
            if (memory_read)
                read_active <= 1'b1;
            else if (i_bus_read_done)
                read_active <= 1'b0;
            if (memory_read)
                restart_pending <= 1'b0;
            else if (read_active && backoff_sync)
                restart_pending <= 1'b1;
        end
    end

    // ----------------------------------------
    // Interlock stalls and float operations
    // ----------------------------------------
    // Both pipes in one clock give two counts
    assign interlock_inc = INC_W'({1'b0, i_address_interlock_stall_first})
                         + INC_W'({1'b0, i_address_interlock_stall_second});
    // One valid per internal step; only the four excluded exceptions block
    assign float_hit = i_float_op_valid && (i_float_excluded_exc == '0);
    assign float_inc = {1'b0, float_hit};

    // ----------------------------------------
    // Breakpoint 0 matches and pins
    // ----------------------------------------
    // First pipe always checked, second pipe only while enabled
    assign bp0_first = i_bp0_hit_first;
    assign bp0_second = i_bp0_hit_second && i_breakpoints_enabled;
    assign bp0_inc = INC_W'({1'b0, bp0_first}) + INC_W'({1'b0, bp0_second});
    assign next_pins = {i_bp_hit_other, bp0_first || bp0_second};

    // Pins register on the same edge as the routed increments
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_breakpoint_match_pins <= '0;
        else
            o_breakpoint_match_pins <= next_pins;
    end

    // ----------------------------------------
    // Per-counter routing
    // ----------------------------------------
    ped_event_route u_route_0 (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_event_select(i_event_select_0),
        .i_uncached_read(uncached_inc),
        .i_interlock_stall(interlock_inc),
        .i_float_op(float_inc),
        .i_breakpoint_0(bp0_inc),
        .o_increment(o_increment_0)
    );

    ped_event_route u_route_1 (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_event_select(i_event_select_1),
        .i_uncached_read(uncached_inc),
        .i_interlock_stall(interlock_inc),
        .i_float_op(float_inc),
        .i_breakpoint_0(bp0_inc),
        .o_increment(o_increment_1)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Helper history of the qualified sources
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            past_uncached <= INC_NONE;
            past_interlock <= INC_NONE;
            past_float <= INC_NONE;
            past_bp0 <= INC_NONE;
            past_bp0_pin <= 1'b0;
        end
        else
        begin
            past_uncached <= uncached_inc;
            past_interlock <= interlock_inc;
            past_float <= float_inc;
            past_bp0 <= bp0_inc;
            past_bp0_pin <= bp0_first || bp0_second;
        end
    end

    chk_io_read_none: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_bus_read_io && (i_event_select_0 == CODE_UNCACHED_READ) |=> o_increment_0 == INC_NONE)
        else $error("I/O read produced an uncached read count");
    chk_uncached_read_count: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        memory_read && !restart_pending && (i_event_select_0 == CODE_UNCACHED_READ)
        |=> o_increment_0 == INC_ONE)
        else $error("Noncacheable memory read not counted");
    chk_restart_no_recount: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        restart_pending && memory_read && (i_event_select_1 == CODE_UNCACHED_READ)
        |=> o_increment_1 == INC_NONE)
        else $error("Restarted read counted twice");
    chk_interlock_double: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_address_interlock_stall_first && i_address_interlock_stall_second
        && (i_event_select_1 == CODE_INTERLOCK_STALL) |=> o_increment_1 == 2'h2)
        else $error("Dual interlock not counted twice");
    chk_interlock_single: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_address_interlock_stall_first != i_address_interlock_stall_second)
        && (i_event_select_0 == CODE_INTERLOCK_STALL) |=> o_increment_0 == INC_ONE)
        else $error("Single interlock miscounted");
    chk_float_excluded: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_float_excluded_exc != '0) && (i_event_select_0 == CODE_FLOAT_OP) |=> o_increment_0 == INC_NONE)
        else $error("Excluded exception counted");
    chk_float_counted: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_float_op_valid && (i_float_excluded_exc == '0) && (i_event_select_1 == CODE_FLOAT_OP)
        |=> o_increment_1 == INC_ONE)
        else $error("Float operation not counted");
    chk_second_pipe_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        !i_breakpoints_enabled && !i_bp0_hit_first |=> !o_breakpoint_match_pins[BP0_BIT])
        else $error("Second pipe match checked while disabled");
    chk_first_pipe_on: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_bp0_hit_first && (i_event_select_0 == CODE_BREAKPOINT_0)
        |=> o_breakpoint_match_pins[BP0_BIT] && (o_increment_0 != INC_NONE))
        else $error("First pipe match not counted");
    chk_pin_coincide: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_event_select_1 == CODE_BREAKPOINT_0) ##1 $past(i_event_select_1) == i_event_select_1
        |-> (o_increment_1 != INC_NONE) == o_breakpoint_match_pins[BP0_BIT])
        else $error("Match count and pin disagree");
    chk_reserved_silent: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (i_event_select_0 == CODE_RESERVED_A) || (i_event_select_0 == CODE_RESERVED_B)
        |=> o_increment_0 == INC_NONE)
        else $error("Reserved code produced a count");
    chk_route_match: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        ##1 ($past(i_event_select_1) == CODE_FLOAT_OP) |-> o_increment_1 == past_float)
        else $error("Routed increment differs from source");
endmodule
`default_nettype wire

// >>> rtl/ped_event_route.sv
// Routes one counter's selected event increment to a registered output
`default_nettype none
module ped_event_route
    import ped_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [ped_pkg::SEL_W-1:0] i_event_select,
    input wire logic [ped_pkg::INC_W-1:0] i_uncached_read,
    input wire logic [ped_pkg::INC_W-1:0] i_interlock_stall,
    input wire logic [ped_pkg::INC_W-1:0] i_float_op,
    input wire logic [ped_pkg::INC_W-1:0] i_breakpoint_0,
    output logic [ped_pkg::INC_W-1:0] o_increment
);
    logic [INC_W-1:0] next_increment;

    // Code match picks one source; reserved and foreign codes give none
    assign next_increment = (i_event_select == CODE_UNCACHED_READ) ? i_uncached_read :
                            (i_event_select == CODE_INTERLOCK_STALL) ? i_interlock_stall :
                            (i_event_select == CODE_FLOAT_OP) ? i_float_op :
                            (i_event_select == CODE_BREAKPOINT_0) ? i_breakpoint_0 : INC_NONE;

    // Increment register
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_increment <= INC_NONE;
        else
            o_increment <= next_increment;
    end
endmodule
`default_nettype wire

// >>> tb/ped_counter_model.sv
// Counter-side model that adds up the increments handed to both counters
`default_nettype none
module ped_counter_model
    import ped_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [ped_pkg::INC_W-1:0] i_increment_0,
    input wire logic [ped_pkg::INC_W-1:0] i_increment_1,
    output logic [31:0] o_total_0,
    output logic [31:0] o_total_1
);
    timeunit 1ns;
    timeprecision 1ns;
    // Accumulate what each counter would add this cycle
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_total_0 <= 32'h0;
            o_total_1 <= 32'h0;
        end
        else
        begin
            o_total_0 <= o_total_0 + 32'(i_increment_0);
            o_total_1 <= o_total_1 + 32'(i_increment_1);
        end
    end
endmodule
`default_nettype wire

// >>> tb/ped_event_detect_tb.sv
// Self-checking bench for the event-qualification block
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ped_event_detect_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ped_pkg::*;
    typedef struct packed {
        logic start, nc, io, done, bus_backoff_input_n, agi_1, agi_2, fp_v;
        logic [FP_EXC_W-1:0] fp_exc;
        logic bp_en, bp_1, bp_2;
        logic [BP_W-1:1] bp_oth;
        logic [SEL_W-1:0] sel_0, sel_1;
    } ped_stim_s;
    typedef struct packed {
        logic [INC_W-1:0] inc_0, inc_1;
        logic [BP_W-1:0] pins;
        time t;
    } ped_note_s;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    ped_stim_s stim = '{bus_backoff_input_n: 1'b1, default: '0};
    ped_stim_s drv = '{bus_backoff_input_n: 1'b1, default: '0};
    ped_note_s notes[$];
    ped_note_s note;
    logic [BP_W-1:0] o_breakpoint_match_pins;
    logic [INC_W-1:0] o_increment_0, o_increment_1;
    logic [31:0] total_0, total_1;
    logic [31:0] sum_0 = 32'h0;
    logic [31:0] sum_1 = 32'h0;
    logic restart_read = 1'b0;
    logic [SEL_W-1:0] codes[7] = '{CODE_UNCACHED_READ, CODE_INTERLOCK_STALL, CODE_RESERVED_A, CODE_RESERVED_B,
        CODE_FLOAT_OP, CODE_BREAKPOINT_0, 8'h00};
    int fails = 0;
    int tests_run = 0;
    ped_event_detect dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_bus_read_start(drv.start),
        .i_bus_read_noncacheable(drv.nc), .i_bus_read_io(drv.io), .i_bus_read_done(drv.done),
        .i_bus_backoff_input_n(drv.bus_backoff_input_n), .i_address_interlock_stall_first(drv.agi_1),
        .i_address_interlock_stall_second(drv.agi_2), .i_float_op_valid(drv.fp_v),
        .i_float_excluded_exc(drv.fp_exc), .i_breakpoints_enabled(drv.bp_en), .i_bp0_hit_first(drv.bp_1),
        .i_bp0_hit_second(drv.bp_2), .i_bp_hit_other(drv.bp_oth), .i_event_select_0(drv.sel_0),
        .i_event_select_1(drv.sel_1), .o_breakpoint_match_pins(o_breakpoint_match_pins),
        .o_increment_0(o_increment_0), .o_increment_1(o_increment_1));
    ped_counter_model partner (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_increment_0(o_increment_0),
        .i_increment_1(o_increment_1), .o_total_0(total_0), .o_total_1(total_1));
    // Expected increment for one counter from the bench's own event rules
    function automatic logic [INC_W-1:0] ev(input logic [SEL_W-1:0] code, input ped_stim_s s);
        case (code)
            CODE_UNCACHED_READ: ev = {1'b0, s.start & s.nc & ~s.io & ~restart_read};
            CODE_INTERLOCK_STALL: ev = {1'b0, s.agi_1} + {1'b0, s.agi_2};
            CODE_FLOAT_OP: ev = {1'b0, s.fp_v & (s.fp_exc == 4'h0)};
            CODE_BREAKPOINT_0: ev = {1'b0, s.bp_1} + {1'b0, s.bp_en & s.bp_2};
            default: ev = INC_NONE;
        endcase
    endfunction
    // Drive one cycle of stimulus and note what it should produce
    task automatic cyc();
        ped_note_s n;
        @(posedge i_ref_clk);
        drv <= stim;
        n.inc_0 = ev(stim.sel_0, stim);
        n.inc_1 = ev(stim.sel_1, stim);
        n.pins = {stim.bp_oth, stim.bp_1 | (stim.bp_en & stim.bp_2)};
        n.t = $time;
        notes.push_back(n);
    endtask
    // Final totals, counts and verdict
    task automatic wrap_up();
        repeat (3) @(posedge i_ref_clk);
        `CHK(total_0, sum_0)
        `CHK(total_1, sum_1)
        $display("counts: run=%0d bad=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Clock
    initial
    begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // Compare each settled output cycle with the oldest note
    always @(negedge i_ref_clk)
    begin
        if (notes.size() > 0 && $time - notes[0].t > 10)
        begin
            note = notes.pop_front();
            `CHK(o_increment_0, note.inc_0)
            `CHK(o_increment_1, note.inc_1)
            `CHK(o_breakpoint_match_pins, note.pins)
            sum_0 = sum_0 + 32'(note.inc_0);
            sum_1 = sum_1 + 32'(note.inc_1);
        end
    end
    // Hang guard
    initial
    begin
        #20000;
        fails++;
        wrap_up();
    end
    // Main sequence
    initial
    begin
        void'($urandom(32'h1B5F665A));
        repeat (10) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        stim.sel_0 = CODE_UNCACHED_READ;
        stim.sel_1 = CODE_BREAKPOINT_0;
        for (int k = 0; k < 4; k++)
        begin
            stim.start = 1'b1;
            stim.nc = k[0];
            stim.io = k[1];
            cyc();
            stim.start = 1'b0;
            stim.done = 1'b1;
            cyc();
            stim.done = 1'b0;
        end
        $display("test read kinds done");
        stim.io = 1'b0;
        stim.nc = 1'b1;
        stim.sel_1 = CODE_UNCACHED_READ;
        for (int k = 0; k < 11; k++)
        begin
            stim.start = (k == 0 || k == 6 || k == 9);
            stim.done = (k == 7 || k == 10);
            stim.bus_backoff_input_n = !(k == 2 || k == 3);
            restart_read = (k == 6);
            cyc();
        end
        restart_read = 1'b0;
        stim = '{bus_backoff_input_n: 1'b1, default: '0};
        $display("test backoff restart done");
        for (int k = 0; k < 12; k++)
        begin
            stim = '{start: 1'b1, nc: 1'b1, bus_backoff_input_n: 1'b1, agi_1: 1'b1, agi_2: 1'b1, fp_v: 1'b1, bp_en: k[0],
                bp_1: 1'b1, bp_2: 1'b1, sel_0: codes[k / 2], sel_1: codes[5 - k / 2], default: '0};
            cyc();
        end
        stim = '{bus_backoff_input_n: 1'b1, default: '0};
        $display("test every code done");
        for (int k = 0; k < 300; k++)
        begin
            stim.agi_1 = 1'($urandom);
            stim.agi_2 = 1'($urandom);
            stim.fp_v = 1'($urandom);
            stim.fp_exc = 4'($urandom) & 4'($urandom) & 4'($urandom);
            stim.bp_en = 1'($urandom);
            stim.bp_1 = 1'($urandom);
            stim.bp_2 = 1'($urandom);
            stim.bp_oth = 3'($urandom);
            stim.sel_0 = codes[$urandom_range(0, 6)];
            stim.sel_1 = codes[$urandom_range(0, 6)];
            cyc();
        end
        stim = '{bus_backoff_input_n: 1'b1, default: '0};
        cyc();
        $display("test random mix done");
        wrap_up();
    end
endmodule
`default_nettype wire
